/* rtl/clkgen_defines.svh */
// Offsets, field positions, reset values and timing counts of the clock block.
// Assumes nothing; it is included by the package users before any module.
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

`define CLK_PERIOD_NS     50

// Register indices; the byte address on the bus is four times the index.
`define IDX_CPU_DIV       8'h95
`define IDX_RC_TUNE       8'h96
`define IDX_STATUS        8'h97

`define TUNE_W            6
`define TUNE_EN_BIT       6
`define TUNE_FACTORY      6'h20
`define DIV_RESET         8'h00

// Source selection codes held in the non-volatile configuration.
`define SRC_RC            3'h0
`define SRC_WDT           3'h1
`define SRC_XLOW          3'h2
`define SRC_XMED          3'h3
`define SRC_XHIGH         3'h4
`define SRC_EXT           3'h5

// Crystal amplifier range codes.
`define XG_OFF            2'h0
`define XG_LOW            2'h1
`define XG_MED            2'h2
`define XG_HIGH           2'h3

`define WAKE_XTAL_CYC     10'd992
`define WAKE_OTHER_CYC    10'd224
`define ANALOG_DELAY_NS   60000
`define ANALOG_DELAY_CYC  ((`ANALOG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Status register fields.
`define ST_SRC_LSB        0
`define ST_RUN_BIT        3
`define ST_DRIVE_BIT      4

`endif

/* rtl/clkgen_pkg.sv */
// Types shared by the clock generation block and its wake-up timer.
// Assumes a single clock domain on hclk.
package clkgen_pkg;

  typedef struct packed {
    logic osc;
    logic cpu;
    logic pclk;
    logic mcycle;
  } clk_ticks_s;

  typedef struct packed {
    logic [2:0] src;
    logic       rtc_on_xtal;
  } osc_cfg_s;

  typedef enum logic [1:0] {
    wake_osc,
    wake_analog,
    wake_run
  } wake_state_e;

endpackage

/* rtl/wake_timer.sv */
// Wake-up hold timer: counts oscillator ticks, then a fixed analog delay.
// Assumes osc_tick is a one-cycle pulse on hclk per oscillator edge.
`include "clkgen_defines.svh"

module wake_timer (
  input  wire logic hclk,      // System clock.
  input  wire logic hresetn,   // Asynchronous reset, active low.
  input  wire logic ce,        // Clock enable; freezes state when low.
  input  wire logic restart,   // Start a new hold period.
  input  wire logic osc_tick,  // One pulse per oscillator clock.
  input  wire logic xtal_src,  // A crystal range is selected.
  output logic      run        // Hold period over.
);

  clkgen_pkg::wake_state_e state_q;
  logic [9:0]              osc_cnt_q;
  logic [10:0]             dly_cnt_q;
  logic [9:0]              limit;

  assign limit = xtal_src ? `WAKE_XTAL_CYC : `WAKE_OTHER_CYC;
  assign run   = (state_q == clkgen_pkg::wake_run);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= clkgen_pkg::wake_osc;
    end else if (ce) begin
      if (restart) begin
        state_q <= clkgen_pkg::wake_osc;
      end else begin
        case (state_q)
          clkgen_pkg::wake_osc: begin
            if (osc_tick && osc_cnt_q == limit - 10'h1) begin
              state_q <= clkgen_pkg::wake_analog;
            end
          end
          clkgen_pkg::wake_analog: begin
            if (dly_cnt_q == 11'(`ANALOG_DELAY_CYC - 1)) begin
              state_q <= clkgen_pkg::wake_run;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_q <= 10'h0;
      dly_cnt_q <= 11'h0;
    end else if (ce) begin
      if (restart || state_q == clkgen_pkg::wake_run) begin
        osc_cnt_q <= 10'h0;
        dly_cnt_q <= 11'h0;
      end else if (state_q == clkgen_pkg::wake_osc) begin
        if (osc_tick) begin
          osc_cnt_q <= osc_cnt_q + 10'h1;
        end
      end else begin
        dly_cnt_q <= dly_cnt_q + 11'h1;
      end
    end
  end

  // Helper: oscillator ticks seen since the last restart, saturating.
  logic [10:0] seen_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 11'h0;
    end else if (ce) begin
      if (restart) begin
        seen_q <= 11'h0;
      end else if (osc_tick && seen_q != 11'h7ff) begin
        seen_q <= seen_q + 11'h1;
      end
    end
  end

  chk_wake_osc_count: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(run) |-> (seen_q >= {1'b0, limit}))
    else $error("CPU clock released before the oscillator count.");

endmodule

/* rtl/mcu_clock_generation_control.sv */
// Clock generation and selection: source select, CPU divider, peripheral
// clock, clock output pin and RC tuning register on an AHB-Lite slave.
// Assumes oscillator inputs are asynchronous to hclk and much slower.
//
// Notes on behaviour
// - machine cycle spans two CPU clocks.
// - peripheral clock is CPU clock halved.
// - oscillator clock from one of four configured sources.
// - CPU clock divides oscillator clock, up to 510.
// - crystal offers low, medium, high ranges.
// - clock output only without crystal use anywhere.
// - clock output driven only when enable set.
// - clock output toggles on every CPU clock, so runs at half CPU rate.
// - six-bit writable RC tuning field.
// - tuning reloads on power-on reset only.
// - watchdog oscillator selectable as clock source.
// - external clock on first pin, second released.
// - hold CPU clock after wake-up.
//
// Local design decision: the AHB-Lite register port.
`include "clkgen_defines.svh"

module mcu_clock_generation_control (
  input  wire logic                   hclk,               // 20 MHz clock.
  input  wire logic                   hresetn,            // Power-on reset, active low.
  input  wire logic                   ce,                 // Clock enable.
  input  wire logic                   hsel,               // AHB select.
  input  wire logic [31:0]            haddr,              // AHB address.
  input  wire logic [1:0]             htrans,             // AHB transfer type.
  input  wire logic                   hwrite,             // AHB write.
  input  wire logic [2:0]             hsize,              // AHB size.
  input  wire logic [31:0]            hwdata,             // AHB write data.
  input  wire logic                   hready,             // AHB ready in.
  output logic                        hreadyout,          // AHB ready out.
  output logic [31:0]                 hrdata,             // AHB read data.
  output logic                        hresp,              // AHB response.
  input  wire clkgen_pkg::osc_cfg_s   cfg,                // Non-volatile setup.
  input  wire logic                   sys_reset_req,      // Other reset source.
  input  wire logic                   wake_req,           // Wake-up event.
  input  wire logic                   rc_osc_clock,       // RC oscillator.
  input  wire logic                   wdt_osc_clock,      // Watchdog oscillator.
  input  wire logic                   first_crystal_pin,  // Crystal or ext clock.
  output clkgen_pkg::clk_ticks_s      ticks,              // Clock enable pulses.
  output logic                        cpu_running,        // Wake hold over.
  output logic [1:0]                  xtal_gain,          // Crystal range.
  output logic [`TUNE_W-1:0]          rc_tune,            // RC tuning value.
  output logic                        second_pin_out,     // Clock output level.
  output logic                        second_pin_oe_n,    // Low while driving.
  output logic                        second_pin_port     // Port owns the pin.
);

  // Strap capture after reset release.
  clkgen_pkg::osc_cfg_s cfg_q;
  logic                 cfg_ok_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q    <= '0;
      cfg_ok_q <= 1'b0;
    end else if (ce && !cfg_ok_q) begin
      cfg_q    <= cfg;
      cfg_ok_q <= 1'b1;
    end
  end

  logic xtal_src;
  assign xtal_src = (cfg_q.src == `SRC_XLOW) || (cfg_q.src == `SRC_XMED) ||
                    (cfg_q.src == `SRC_XHIGH);

  // Oscillator synchronisers, reset high: a pin idling high then gives no false edge.
  logic [2:0] osc_raw;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] sync3_q;
  logic [2:0] osc_rise;

  assign osc_raw = {first_crystal_pin, wdt_osc_clock, rc_osc_clock};

  generate
    for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_q[g] <= 1'b1;
          sync2_q[g] <= 1'b1;
          sync3_q[g] <= 1'b1;
        end else if (ce) begin
          sync1_q[g] <= osc_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
        end
      end
    end
  endgenerate

  assign osc_rise = sync2_q & ~sync3_q;

  logic osc_edge;
  always_comb begin
    case (cfg_q.src)
      `SRC_WDT:   osc_edge = osc_rise[1];
      `SRC_XLOW:  osc_edge = osc_rise[2];
      `SRC_XMED:  osc_edge = osc_rise[2];
      `SRC_XHIGH: osc_edge = osc_rise[2];
      `SRC_EXT:   osc_edge = osc_rise[2];
      default:    osc_edge = osc_rise[0];
    endcase
  end

  // Wake-up hold.
  logic run;
  logic restart;
  assign restart = !cfg_ok_q || sys_reset_req || wake_req;

  wake_timer u_wake (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .restart  (restart),
    .osc_tick (osc_edge),
    .xtal_src (xtal_src),
    .run      (run)
  );

  // Registers.
  logic [7:0]        div_q;
  logic [`TUNE_W:0]  tune_q;
  logic              wr_q;
  logic [7:0]        widx_q;
  logic              acc;
  logic              mapped;
  logic [7:0]        idx;

  assign acc    = hsel && hready && htrans[1];
  assign mapped = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
  assign idx    = haddr[9:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      widx_q <= 8'h00;
    end else if (ce) begin
      wr_q   <= acc && hwrite && mapped;
      widx_q <= idx;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= `DIV_RESET;
    end else if (ce) begin
      if (sys_reset_req) begin
        div_q <= `DIV_RESET;
      end else if (wr_q && widx_q == `IDX_CPU_DIV) begin
        div_q <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tune_q <= {1'b0, `TUNE_FACTORY};
    end else if (ce && wr_q && widx_q == `IDX_RC_TUNE) begin
      tune_q <= hwdata[`TUNE_W:0];
    end
  end

  logic drive_q;
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (idx == `IDX_CPU_DIV) begin
      rd_val[7:0] = div_q;
    end else if (idx == `IDX_RC_TUNE) begin
      rd_val[`TUNE_W:0] = tune_q;
    end else if (idx == `IDX_STATUS) begin
      rd_val[`ST_SRC_LSB +: 3] = cfg_q.src;
      rd_val[`ST_RUN_BIT]      = run;
      rd_val[`ST_DRIVE_BIT]    = drive_q;
    end
  end

  // Zero wait states; every answer is OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (acc && !hwrite && mapped) ? rd_val : 32'h0;
    end
  end

  logic [8:0] cnt_q;
  logic [8:0] limit9;
  logic       cpu_tick;
  logic       phase_q;

  assign limit9   = {div_q, 1'b0};
  assign cpu_tick = run && osc_edge &&
                    (div_q == 8'h00 || cnt_q >= limit9 - 9'h1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 9'h0;
    end else if (ce) begin
      if (!run || cpu_tick) begin
        cnt_q <= 9'h0;
      end else if (osc_edge) begin
        cnt_q <= cnt_q + 9'h1;
      end
    end
  end

  // two CPU clocks per machine cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        phase_q <= 1'b0;
      end else if (cpu_tick) begin
        phase_q <= !phase_q;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ticks <= '0;
    end else if (ce) begin
      ticks.osc    <= osc_edge;
      ticks.cpu    <= cpu_tick;
      ticks.pclk   <= cpu_tick && phase_q;
      ticks.mcycle <= cpu_tick && phase_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xtal_gain   <= `XG_OFF;
      cpu_running <= 1'b0;
      rc_tune     <= `TUNE_FACTORY;
    end else if (ce) begin
      cpu_running <= run;
      rc_tune     <= tune_q[`TUNE_W-1:0];
      if (cfg_q.src == `SRC_XLOW) begin
        xtal_gain <= `XG_LOW;
      end else if (cfg_q.src == `SRC_XMED) begin
        xtal_gain <= `XG_MED;
      end else if (cfg_q.src == `SRC_XHIGH) begin
        xtal_gain <= `XG_HIGH;
      end else begin
        xtal_gain <= `XG_OFF;
      end
    end
  end

  logic permit;
  assign permit = cfg_ok_q && !xtal_src && !cfg_q.rtc_on_xtal &&
                  tune_q[`TUNE_EN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_q         <= 1'b0;
      second_pin_oe_n <= 1'b1;
      second_pin_port <= 1'b0;
    end else if (ce) begin
      drive_q         <= permit;
      second_pin_oe_n <= !permit;
      second_pin_port <= cfg_ok_q && !permit && !xtal_src;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_pin_out <= 1'b0;
    end else if (ce) begin
      if (!permit) begin
        second_pin_out <= 1'b0;
      end else if (cpu_tick) begin
        second_pin_out <= !second_pin_out;
      end
    end
  end

  // Helper for checks: CPU ticks since the last peripheral tick.
  logic [1:0] gap_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_q <= 2'h0;
    end else if (ce && (!run || ticks.pclk)) begin
      gap_q <= 2'h0;
    end else if (ce && ticks.cpu && gap_q != 2'h3) begin
      gap_q <= gap_q + 2'h1;
    end
  end

  sequence s_soft_reset;
    sys_reset_req && ce && !(wr_q && widx_q == `IDX_RC_TUNE);
  endsequence

  sequence s_fast_div;
    ce && run && div_q == 8'h00 && osc_edge;
  endsequence

  chk_pclk_from_cpu: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ticks.pclk |-> ticks.cpu && gap_q == 2'h1)
    else $error("Peripheral tick not on every second CPU tick.");

  chk_mcycle_two_cpu_clock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ticks.cpu && gap_q == 2'h1 |-> ticks.mcycle)
    else $error("Machine cycle not aligned to two CPU clocks.");

  chk_div_one_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_fast_div |=> ticks.cpu && ticks.osc)
    else $error("Divide by one did not pass the oscillator tick.");

  chk_tune_keep_soft: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_soft_reset |=> $stable(tune_q))
    else $error("Tuning register changed on a non power-on reset.");

  chk_clkout_permit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !second_pin_oe_n |-> $past(!xtal_src && !cfg_q.rtc_on_xtal))
    else $error("Clock output driven while the crystal is in use.");

  chk_clkout_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(tune_q[`TUNE_EN_BIT]) && ce |=> second_pin_oe_n && !second_pin_out)
    else $error("Clock output still driven after enable cleared.");

  chk_clkout_half: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $changed(second_pin_out) && !second_pin_oe_n |-> ticks.cpu)
    else $error("Clock output toggled without a CPU tick.");

  chk_wake_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && !run |=> !ticks.cpu)
    else $error("CPU tick during the wake-up hold.");

  chk_port_return: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce && cfg_ok_q && !permit && !xtal_src |=> second_pin_port && second_pin_oe_n)
    else $error("Second pin not returned to port use.");

endmodule

/* tb/osc_source_model.sv */
// Oscillator sources for the clock block: RC, watchdog and crystal pin.
// Assumes the rates stay well below a quarter of hclk, as the block's
// synchronisers need, so the real rates are scaled down here.
module osc_source_model #(
  parameter int RC_NS  = 310,  // Scaled RC oscillator period.
  parameter int WDT_NS = 2510, // Watchdog oscillator period.
  parameter int XT_NS  = 350   // Crystal or external clock period.
) (
  input  wire logic [1:0] xtal_gain, // Amplifier range from the block.
  input  wire logic       ext_on,    // Board drives an external clock.
  output logic            rc_clk,    // RC oscillator.
  output logic            wdt_clk,   // Watchdog oscillator.
  output logic            xt_pin     // First crystal pin level.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic xt_q;
  initial begin
    rc_clk = 1'b0;
    wdt_clk = 1'b0;
    xt_q = 1'b0;
  end
  always #(RC_NS / 2) rc_clk = ~rc_clk;
  always #(WDT_NS / 2) wdt_clk = ~wdt_clk;
  always #(XT_NS / 2) xt_q = ~xt_q;
  // crystal or source.
  // A resonator only swings with its amplifier on, and the rate is far below
  // 12 MHz, so the board may leave the reset-capable pin as a port.
  assign xt_pin = (xtal_gain != 2'h0 || ext_on) ? xt_q : 1'b0;
endmodule

/* tb/tb_mcu_clock_generation_control.sv */
// Self-checking bench for the clock block, driven over AHB-Lite.
// Assumes the oscillator model beside it and a zero-wait-state slave.
`include "clkgen_defines.svh"

module tb_mcu_clock_generation_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 95000;
  typedef struct {string nm; logic [31:0] v;} note_s;
  logic                   hclk, hresetn, ce, hsel, hwrite, hready, hresp;
  logic                   sys_reset_req, wake_req, rd_ph, cpu_running;
  logic                   rc_clk, wdt_clk, xt_pin, pin_out, pin_oe_n, pin_port;
  logic [31:0]            haddr, hwdata, hrdata;
  logic [1:0]             htrans, xtal_gain;
  logic [2:0]             hsize;
  logic [5:0]             rc_tune, t;
  clkgen_pkg::osc_cfg_s   cfg;
  clkgen_pkg::clk_ticks_s ticks;
  note_s                  exp_q[$];
  int                     err_count, checks_done, cyc;

  mcu_clock_generation_control u_mcu_clock_generation_control (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .cfg(cfg), .sys_reset_req(sys_reset_req), .wake_req(wake_req),
    .rc_osc_clock(rc_clk), .wdt_osc_clock(wdt_clk), .first_crystal_pin(xt_pin),
    .ticks(ticks), .cpu_running(cpu_running), .xtal_gain(xtal_gain),
    .rc_tune(rc_tune), .second_pin_out(pin_out), .second_pin_oe_n(pin_oe_n),
    .second_pin_port(pin_port));

  osc_source_model u_osc_source_model (
    .xtal_gain(xtal_gain), .ext_on(cfg.src == 3'h5), .rc_clk(rc_clk),
    .wdt_clk(wdt_clk), .xt_pin(xt_pin));

  initial hclk = 1'b0;
  always #25 hclk = ~hclk;

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Read data is judged in its data phase against the oldest note.
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (rd_ph === 1'b1) begin
      check(exp_q[0].nm, exp_q[0].v, hrdata);
      void'(exp_q.pop_front());
    end
    if (cyc == LIMIT) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic wait_rdy();
    do @(posedge hclk); while (hready !== 1'b1);
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'h0};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_ph <= !wr;
    wait_rdy();
    rd_ph <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
    exp_q.push_back('{nm, e});
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic wait_cpu();
    do @(posedge hclk); while (ticks.cpu !== 1'b1);
  endtask

  task automatic por(input logic [2:0] src, input logic rtc);
    hresetn <= 1'b0;
    cfg <= '{src, rtc};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
  endtask

  // Counts source edges and cycles from reset release to the first CPU tick.
  task automatic wake_check(input int need, input int per);
    int n, tn, c;
    n = 0;
    tn = 0;
    c = 0;
    while (ticks.cpu !== 1'b1) begin
      @(posedge hclk);
      c++;
      if (ticks.osc === 1'b1) n++;
      if (n == need && tn == 0) tn = c;
    end
    check("wake osc edges", 32'h1, 32'(n >= need));
    check("wake delay", 32'h1, 32'(c - tn >= 1200 && c - tn <= 1200 + per + 8));
  endtask

  // Over one peripheral period: two CPU ticks, each 2N source edges, or one edge when N is zero.
  task automatic div_check(input logic [7:0] n);
    int o, c, m;
    o = 0;
    c = 0;
    m = 0;
    bus(1'b1, 8'h95, {24'h0, n});
    do @(posedge hclk); while (ticks.pclk !== 1'b1);
    do begin
      @(posedge hclk);
      o += int'(ticks.osc);
      c += int'(ticks.cpu);
      m += int'(ticks.mcycle);
    end while (ticks.pclk !== 1'b1);
    check("cpu per pclk", 32'd2, 32'(c));
    check("mcycle per pclk", 32'd1, 32'(m));
    check("osc per pclk", 32'(n == 8'h0 ? 2 : 4 * n), 32'(o));
  endtask

  initial begin
    int k, tg;
    logic p;
    void'($urandom(49714));
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sys_reset_req = 1'b0;
    wake_req = 1'b0;
    rd_ph = 1'b0;
    cfg = '0;
    cyc = 0;
    err_count = 0;
    checks_done = 0;
    por(3'h0, 1'b0);
    rd("unmapped", 8'h98, 32'h0);
    bus(1'b1, 8'h98, 32'hffffffff);
    rd("unmapped", 8'h98, 32'h0);
    check("hresp", 32'h0, 32'(hresp));
    check("hreadyout", 32'h1, 32'(hready));
    rd("divisor", 8'h95, 32'h0);
    t = 6'($urandom);
    bus(1'b1, 8'h96, {26'h0, t});
    rd("tune", 8'h96, {26'h0, t});
    check("tune port", 32'(t), 32'(rc_tune));
    bus(1'b1, 8'h95, 32'h5);
    sys_reset_req <= 1'b1;
    @(posedge hclk);
    sys_reset_req <= 1'b0;
    @(posedge hclk);
    rd("tune kept", 8'h96, {26'h0, t});
    rd("divisor cleared", 8'h95, 32'h0);
    div_check(8'h0);
    div_check(8'h1);
    div_check(8'hff);
    div_check(8'(2 + $urandom % 30));
    div_check(8'h2);
    bus(1'b1, 8'h96, {25'h0, 1'b1, t});
    repeat (2) @(posedge hclk);
    check("pin driven", 32'h0, 32'(pin_oe_n));
    check("pin port", 32'h0, 32'(pin_port));
    wait_cpu();
    p = pin_out;
    k = 0;
    tg = 0;
    while (k < 8) begin
      @(posedge hclk);
      k += int'(ticks.cpu);
      tg += int'(pin_out !== p);
      p = pin_out;
    end
    check("clock out toggles", 32'd8, 32'(tg));
    // A low clock enable must freeze the divider and the clock output.
    ce <= 1'b0;
    @(posedge hclk);
    k = int'(ticks);
    p = pin_out;
    repeat (40) @(posedge hclk);
    check("frozen ticks", 32'(k), 32'(ticks));
    check("frozen pin", 32'(p), 32'(pin_out));
    ce <= 1'b1;
    bus(1'b1, 8'h96, {26'h0, t});
    repeat (2) @(posedge hclk);
    check("pin released", 32'h1, 32'(pin_oe_n));
    check("pin back to port", 32'h1, 32'(pin_port));
    check("pin level", 32'h0, 32'(pin_out));
    wake_req <= 1'b1;
    @(posedge hclk);
    wake_req <= 1'b0;
    repeat (3) @(posedge hclk);
    check("hold after wake", 32'h0, 32'(cpu_running));
    por(3'h0, 1'b1);
    bus(1'b1, 8'h96, 32'h40);
    repeat (2) @(posedge hclk);
    check("rtc on crystal", 32'h1, 32'(pin_oe_n));
    for (int s = 0; s < 6; s++) begin
      por(3'(s), 1'b0);
      wake_check((s >= 2 && s <= 4) ? 992 : 224, s == 1 ? 51 : 7);
      check("xtal gain", 32'((s >= 2 && s <= 4) ? s - 1 : 0), 32'(xtal_gain));
      check("running", 32'h1, 32'(cpu_running));
      rd("tune after por", 8'h96, 32'h20);
      bus(1'b1, 8'h96, 32'h40);
      repeat (2) @(posedge hclk);
      k = (s >= 2 && s <= 4) ? 0 : 1;
      rd("status", 8'h97, {27'h0, 1'(k), 1'b1, 3'(s)});
      check("pin enable", 32'(k == 0), 32'(pin_oe_n));
    end
    print_verdict();
  end
endmodule
